// *** design/srh_params.svh ***
// Constants for the split-read and retry bus host.
// Assumes inclusion by the package, the host module, the guest model and the bench.
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH
`define SRH_TYPE_IDLE   4'h0
`define SRH_TYPE_READ   4'h1
`define SRH_TYPE_WRITE  4'h2
`define SRH_TYPE_RDRET  4'h3
`define SRH_RETRY_WAIT  5'h10
`define SRH_PEND_TMO    16380
`define SRH_FIFO_DEPTH  4
`define SRH_ST_OK       2'h0
`define SRH_ST_PATH     2'h1
`define SRH_ST_TMO      2'h2
`endif

// *** design/srh_pkg.sv ***
// Types for the split-read and retry bus host.
// Assumes the constants header sits beside it.
`include "srh_params.svh"
package srh_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ADDR  = 3'h1,
      ST_WDAT  = 3'h2,
      ST_RWAIT = 3'h3,
      ST_LOCK  = 3'h4,
      ST_RHDR  = 3'h5,
      ST_RDAT  = 3'h6,
      ST_GUEST = 3'h7
   } srh_state_t;
endpackage : srh_pkg

// *** design/srh_host.sv ***
// Bus host for split reads, busy-retry and lock-split on an expansion bus.
// Assumes one bus clock; guests own the pins' far ends; the command queue sits outside.
// How it works
// - host drives pend and return lines, hears acknowledge
// - pend line at guest grant only if acceptable
// - return: strobe plus guest grant, then data
// - strobe and grant drop on last data
// - pend line in I/O read address cycle
// - pended read: save context, end transaction
// - read return data forwarded to inbound queue
// - one outstanding split read; return address ignored
// - no pend line on host reads while read outstanding
// - unexpected read return raises bus error
// - retry refuses; host repeats same transaction later
// - host keeps mastering after a split read
// - lock-split suspends, release resumes host transaction
// - retry ends transaction and frees the bus
// - retry after 16 cycles, guest sequence, return
// - error while waiting drops it, path error for a read
// - split read times out, reports timeout
// - refused command blocks queue head
`timescale 1ns/1ns
`default_nettype none
`include "srh_params.svh"

module srh_fifo #(
   parameter int W = 34,
   parameter int D = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;
   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   always_ff @(posedge sys_clk) if (do_wr) mem_r[wp_r] <= in_data;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_r + AW'(do_wr);
         rp_r  <= rp_r + AW'(do_rd);
         cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : srh_fifo

module srh_host import srh_pkg::*; #(
   parameter int NG       = 4,
   parameter int PEND_TMO = `SRH_PEND_TMO
) (
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   input  wire logic          cmd_valid,
   output logic               cmd_ready,
   input  wire logic          cmd_write,
   input  wire logic [31:0]   cmd_addr,
   input  wire logic [31:0]   cmd_wdata,
   output logic               rsp_valid,
   input  wire logic          rsp_ready,
   output logic [31:0]        rsp_data,
   output logic [1:0]         rsp_status,
   input  wire logic          dma_ret_valid,
   output logic               dma_ret_ready,
   input  wire logic [NG-1:0] dma_ret_guest,
   input  wire logic [31:0]   dma_ret_data,
   input  wire logic          dma_ret_last,
   input  wire logic          pend_ok,
   input  wire logic          hard_err_in,
   output logic               hard_err_log,
   input  wire logic [NG-1:0] guest_req_n,
   output logic [NG-1:0]      guest_grant_n,
   output logic               pend_capable_n,
   output logic               read_return_strobe_n,
   output logic               host_io_txn,
   input  wire logic          pend_ack_n,
   input  wire logic          busy_retry_n,
   input  wire logic          lock_split_n,
   input  wire logic          slave_ack_n,
   output logic               bus_error_n_o,
   output logic               bus_error_oe,
   input  wire logic [3:0]    type_in,
   output logic [3:0]         type_out,
   input  wire logic [31:0]   ad_in,
   output logic [31:0]        ad_out,
   output logic               ad_oe
);
   localparam int TW = 15;
   localparam int SW = NG + 40;
   if (NG < 1 || PEND_TMO < 1 || PEND_TMO >= (1 << TW)) $error("bad parameters");

   // Pins pass two flip-flops before use
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else begin
         sync1_r <= {guest_req_n, pend_ack_n, busy_retry_n, lock_split_n, slave_ack_n,
                     type_in, ad_in};
         sync2_r <= sync1_r;
      end
   end
   wire [NG-1:0] s_req_n = sync2_r[SW-1 -: NG];
   wire          s_pack  = !sync2_r[39];
   wire          s_retry = !sync2_r[38];
   wire          s_lock  = !sync2_r[37];
   wire          s_ack   = !sync2_r[36];
   wire [3:0]    s_type  = sync2_r[35:32];
   wire [31:0]   s_ad    = sync2_r[31:0];

   function automatic logic [NG-1:0] first_req(input logic [NG-1:0] req);
      logic [NG-1:0] one;
      one = '0;
      for (int i = NG - 1; i >= 0; i--) if (req[i]) one = NG'(1) << i;
      return one;
   endfunction : first_req

   srh_state_t     state_r;
   srh_state_t     state_nxt;
   srh_state_t     lock_ret_r;
   logic [NG-1:0]  gnt_r;
   logic           cur_read_r;
   logic [31:0]    cur_addr_r;
   logic [31:0]    cur_wdata_r;
   logic           pend_en_r;
   logic           pend_ok_r;
   logic           pend_out_r;
   logic [TW-1:0]  tmo_r;
   logic           held_r;
   logic [4:0]     rwait_r;
   logic           seq_done_r;
   logic           ret_done_r;
   logic           rr_data_r;
   logic           err_r;
   logic           fifo_space;

   // Termination decided in the cycle the line is seen
   wire in_txn    = (state_r == ST_RWAIT) || (state_r == ST_WDAT);
   wire do_lock   = in_txn && s_lock;
   wire do_retry  = in_txn && !s_lock && s_retry;
   wire do_pend   = (state_r == ST_RWAIT) && !s_lock && !s_retry && s_pack;
   wire do_ack    = in_txn && !s_lock && !s_retry && !s_pack && s_ack;
   wire push_rd   = do_ack && cur_read_r;
   wire rr_addr   = (state_r == ST_GUEST) && (s_type == `SRH_TYPE_RDRET);
   wire push_rr   = rr_data_r && pend_out_r;
   wire drop      = held_r && (hard_err_in || err_r) && (state_r == ST_IDLE) && !push_rr;
   wire push_drop = drop && cur_read_r;
   wire tmo_hit   = pend_out_r && (tmo_r == '0);
   wire push_tmo  = tmo_hit && !push_rd && !push_rr && !push_drop && fifo_space;
   wire pend_free = !pend_out_r || push_tmo || push_rr;
   wire retry_go  = held_r && !dma_ret_valid &&
                    (rwait_r == `SRH_RETRY_WAIT || seq_done_r || ret_done_r);
   wire issue     = (state_r == ST_IDLE) && !drop && !dma_ret_valid && fifo_space &&
                    (held_r ? retry_go : cmd_valid);
   wire guest_go  = (state_r == ST_IDLE) && !drop && !dma_ret_valid && !issue &&
                    fifo_space && (s_req_n != '1);

   assign cmd_ready = do_ack || do_pend || drop;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  begin
            if (!drop && dma_ret_valid) state_nxt = ST_RHDR;
            else if (issue) state_nxt = ST_ADDR;
            else if (guest_go) state_nxt = ST_GUEST;
         end
         ST_ADDR:  state_nxt = cur_read_r ? ST_RWAIT : ST_WDAT;
         ST_WDAT, ST_RWAIT: begin
            if (do_lock) state_nxt = ST_LOCK;
            else if (do_retry || do_pend || do_ack) state_nxt = ST_IDLE;
         end
         ST_LOCK:  if (!s_lock) state_nxt = lock_ret_r;
         ST_RHDR:  state_nxt = ST_RDAT;
         ST_RDAT:  if (dma_ret_last) state_nxt = ST_IDLE;
         ST_GUEST: if ((s_req_n & gnt_r) != '0) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) state_r <= ST_IDLE;
      else state_r <= state_nxt;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lock_ret_r  <= ST_IDLE;
         gnt_r       <= '0;
         cur_read_r  <= 1'b0;
         cur_addr_r  <= 32'h0000_0000;
         cur_wdata_r <= 32'h0000_0000;
         pend_en_r   <= 1'b0;
         pend_ok_r   <= 1'b0;
      end else begin
         if (do_lock) lock_ret_r <= state_r;
         if (!drop && dma_ret_valid && state_r == ST_IDLE) gnt_r <= dma_ret_guest;
         else if (guest_go) gnt_r <= first_req(~s_req_n);
         if (guest_go) pend_ok_r <= pend_ok;
         if (issue && !held_r) begin
            cur_read_r  <= !cmd_write;
            cur_addr_r  <= cmd_addr;
            cur_wdata_r <= cmd_wdata;
         end
         if (issue) pend_en_r <= (held_r ? cur_read_r : !cmd_write) && pend_free;
      end
   end

   // Split read book-keeping: one outstanding, no guest identity kept
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pend_out_r <= 1'b0;
         tmo_r      <= '0;
         rr_data_r  <= 1'b0;
         err_r      <= 1'b0;
      end else begin
         rr_data_r <= rr_addr;
         err_r     <= rr_addr && !pend_out_r;
         if (do_pend) begin
            pend_out_r <= 1'b1;
            tmo_r      <= TW'(PEND_TMO);
         end else if (push_rr || push_tmo) pend_out_r <= 1'b0;
         else if (pend_out_r && tmo_r != '0) tmo_r <= tmo_r - TW'(1);
      end
   end

   // Refused transaction waits at queue head
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         held_r     <= 1'b0;
         rwait_r    <= 5'h00;
         seq_done_r <= 1'b0;
         ret_done_r <= 1'b0;
      end else begin
         if (do_retry) begin
            held_r     <= 1'b1;
            rwait_r    <= 5'h00;
            seq_done_r <= 1'b0;
            ret_done_r <= 1'b0;
         end else if (do_ack || do_pend || drop) held_r <= 1'b0;
         else if (held_r) begin
            if (rwait_r != `SRH_RETRY_WAIT) rwait_r <= rwait_r + 5'h01;
            if (state_r == ST_GUEST && state_nxt == ST_IDLE) seq_done_r <= 1'b1;
            if (state_r == ST_RDAT && dma_ret_last) ret_done_r <= 1'b1;
         end
      end
   end

   // Pin outputs
   wire ret_hold = (state_r == ST_RHDR) || (state_r == ST_RDAT && !dma_ret_last);
   assign guest_grant_n = ((state_r == ST_GUEST) || ret_hold) ? ~gnt_r : '1;
   assign read_return_strobe_n = !ret_hold;
   assign pend_capable_n = !(((state_r == ST_GUEST) && pend_ok_r) ||
                             ((state_r == ST_ADDR) && pend_en_r));
   assign host_io_txn   = (state_r == ST_ADDR);
   assign type_out      = (state_r != ST_ADDR) ? `SRH_TYPE_IDLE :
                          cur_read_r ? `SRH_TYPE_READ : `SRH_TYPE_WRITE;
   assign ad_oe         = (state_r == ST_ADDR) || (state_r == ST_WDAT) || (state_r == ST_RDAT);
   assign ad_out        = (state_r == ST_ADDR) ? cur_addr_r :
                          (state_r == ST_WDAT) ? cur_wdata_r : dma_ret_data;
   assign dma_ret_ready = (state_r == ST_RDAT);
   assign bus_error_n_o = 1'b0;
   assign bus_error_oe  = err_r;
   assign hard_err_log  = err_r;

   // Inbound responses
   wire        f_push = push_rd || push_rr || push_drop || push_tmo;
   wire [1:0]  f_st   = push_drop ? `SRH_ST_PATH : push_tmo ? `SRH_ST_TMO : `SRH_ST_OK;
   wire [31:0] f_dat  = (push_rd || push_rr) ? s_ad : 32'h0000_0000;
   srh_fifo #(.W(34), .D(`SRH_FIFO_DEPTH)) u_rsp_fifo (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .in_valid  (f_push),
      .in_ready  (fifo_space),
      .in_data   ({f_st, f_dat}),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  ({rsp_status, rsp_data})
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_refused;
      do_retry && !cmd_ready;
   endsequence
   sequence s_back_idle;
      held_r && state_r == ST_IDLE;
   endsequence
   a_ret_release: assert property (state_r == ST_RDAT && dma_ret_last |->
      read_return_strobe_n && guest_grant_n == '1) else $error("return lines held on last data");
   a_ret_start: assert property (state_r == ST_RHDR |->
      !read_return_strobe_n && guest_grant_n == ~gnt_r ##1 state_r == ST_RDAT)
      else $error("return header malformed");
   a_pend_block: assert property (state_r == ST_ADDR && pend_out_r |-> pend_capable_n)
      else $error("pend offered while read outstanding");
   a_pend_addr: assert property (state_r == ST_ADDR && cur_read_r && !pend_out_r |->
      !pend_capable_n) else $error("pend not offered on read");
   a_grant_pend: assert property (state_r == ST_GUEST && !pend_ok_r |-> pend_capable_n)
      else $error("pend offered without capacity");
   a_pend_save: assert property (do_pend |-> cmd_ready ##1 pend_out_r && state_r == ST_IDLE)
      else $error("pended read not saved");
   a_retry_hold: assert property (s_refused |=> s_back_idle)
      else $error("retry not held");
   a_retry_gap: assert property ((s_back_idle and dma_ret_valid) |=> state_r != ST_ADDR)
      else $error("retry before read return");
   a_bad_return: assert property (rr_addr && !pend_out_r |=> bus_error_oe ##1 !bus_error_oe)
      else $error("bad read return not flagged");
   a_lock_resume: assert property (state_r == ST_LOCK && !s_lock |=> state_r == $past(lock_ret_r))
      else $error("lock release did not resume");
endmodule : srh_host
`default_nettype wire

// *** tb/srh_guest_model.sv ***
// Guest model: answers host I/O cycles, sends one read return on request.
// Assumes it is guest 0 and samples host pins on the rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "srh_params.svh"
module srh_guest_model (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [1:0]  mode,
   input  wire logic [1:0]  dly,
   input  wire logic [31:0] rdata,
   input  wire logic        ret_go,
   input  wire logic [31:0] ret_data,
   input  wire logic        host_io_txn,
   input  wire logic        grant_n,
   output logic             req_n,
   output logic             slave_ack_n,
   output logic             pend_ack_n,
   output logic             busy_retry_n,
   output logic             lock_split_n,
   output logic [3:0]       type_in,
   output logic [31:0]      ad_in
);
   logic [2:0] cnt_r;
   logic [2:0] ph_r;
   logic [2:0] lk_r;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 3'h0;
         ph_r <= 3'h0;
         lk_r <= 3'h0;
         lock_split_n <= 1'b1;
         req_n <= 1'b1;
         slave_ack_n <= 1'b1;
         pend_ack_n <= 1'b1;
         busy_retry_n <= 1'b1;
         type_in <= 4'h0;
         ad_in <= 32'h0;
      end else begin
         slave_ack_n <= 1'b1;
         pend_ack_n <= 1'b1;
         busy_retry_n <= 1'b1;
         type_in <= 4'h0;
         lock_split_n <= 1'b1;
         // Released lines toggle so stale data never looks valid
         ad_in <= ~ad_in;
         cnt_r <= host_io_txn ? {1'b0, dly} + 3'h1 : (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
         // Lock-split held for a few cycles, released, then the data answered
         if (lk_r != 3'h0) lk_r <= lk_r - 3'h1;
         if (lk_r > 3'h2) lock_split_n <= 1'b0;
         if (lk_r == 3'h1) begin
            slave_ack_n <= 1'b0;
            ad_in <= rdata;
         end
         if (cnt_r == 3'h1) begin
            case (mode)
               2'h0: begin
                  slave_ack_n <= 1'b0;
                  ad_in <= rdata;
               end
               2'h1: pend_ack_n <= 1'b0;
               2'h2: busy_retry_n <= !grant_n;
               default: begin
                  lock_split_n <= 1'b0;
                  lk_r <= 3'h5;
               end
            endcase
         end
         case (ph_r)
            3'h0: if (ret_go) begin
               req_n <= 1'b0;
               ph_r <= 3'h1;
            end
            3'h1: if (!grant_n) ph_r <= 3'h2;
            3'h2: begin
               type_in <= `SRH_TYPE_RDRET;
               ad_in <= ~ret_data;
               ph_r <= 3'h3;
            end
            3'h3: begin
               ad_in <= ret_data;
               ph_r <= 3'h4;
            end
            default: begin
               req_n <= 1'b1;
               ph_r <= 3'h0;
            end
         endcase
      end
   end
endmodule : srh_guest_model
`default_nettype wire

// *** tb/tb_srh_host.sv ***
// Self-checking bench for the split-read and retry host.
// Assumes the guest model stands as guest 0; other requests come from here.
`timescale 1ns/1ns
`default_nettype none
`include "srh_params.svh"
module tb_srh_host import srh_pkg::*;;
   localparam int TMO = 60;
   logic        sys_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, rsp_ready = 1'b0;
   logic        dma_ret_valid = 1'b0, dma_ret_last = 1'b0, pend_ok = 1'b0, hard_err_in = 1'b0;
   logic        ret_go = 1'b0, cmd_ready, rsp_valid, dma_ret_ready, hard_err_log, req0_n;
   logic        pend_capable_n, read_return_strobe_n, host_io_txn, pend_ack_n, busy_retry_n;
   logic        slave_ack_n, bus_error_oe, ad_oe, pc_seen, lock_n, oe_seen, ph1 = 1'b0;
   logic [1:0]  mode = 2'h0, dly = 2'h0, rsp_status, errs = 2'h0;
   logic [2:0]  req_hi = 3'h7;
   logic [3:0]  guest_grant_n, dma_ret_guest = 4'h0, type_in, type_out, ty_seen;
   logic [31:0] cmd_addr = 32'h0, cmd_wdata = 32'h0, dma_ret_data = 32'h0, rdata = 32'h0;
   logic [31:0] ret_data = 32'h0, rsp_data, ad_in, ad_out, ad_seen, wd_seen;
   int          mismatches = 0, check_count = 0, txn_n = 0, cyc_n = 0, at_r = 0, prev_at = 0;
   always #20 sys_clk = ~sys_clk;
   // Records each host address cycle
   always @(negedge sys_clk) begin
      cyc_n <= cyc_n + 1;
      errs <= errs | {hard_err_log, bus_error_oe};
      ph1 <= host_io_txn;
      if (ph1) begin
         wd_seen <= ad_out;
         oe_seen <= ad_oe;
      end
      if (host_io_txn) begin
         txn_n <= txn_n + 1;
         prev_at <= at_r;
         at_r <= cyc_n;
         pc_seen <= pend_capable_n;
         ty_seen <= type_out;
         ad_seen <= ad_out;
      end
   end
   srh_host #(.NG(4), .PEND_TMO(TMO)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
      .rsp_status(rsp_status), .dma_ret_valid(dma_ret_valid), .dma_ret_ready(dma_ret_ready),
      .dma_ret_guest(dma_ret_guest), .dma_ret_data(dma_ret_data), .dma_ret_last(dma_ret_last),
      .pend_ok(pend_ok), .hard_err_in(hard_err_in), .hard_err_log(hard_err_log),
      .guest_req_n({req_hi, req0_n}), .guest_grant_n(guest_grant_n),
      .pend_capable_n(pend_capable_n), .read_return_strobe_n(read_return_strobe_n),
      .host_io_txn(host_io_txn), .pend_ack_n(pend_ack_n), .busy_retry_n(busy_retry_n),
      .lock_split_n(lock_n), .slave_ack_n(slave_ack_n), .bus_error_n_o(),
      .bus_error_oe(bus_error_oe), .type_in(type_in), .type_out(type_out), .ad_in(ad_in),
      .ad_out(ad_out), .ad_oe(ad_oe));
   srh_guest_model guest_u (.sys_clk(sys_clk), .nrst(nrst), .mode(mode), .dly(dly),
      .rdata(rdata), .ret_go(ret_go), .ret_data(ret_data), .host_io_txn(host_io_txn),
      .grant_n(guest_grant_n[0]), .req_n(req0_n), .slave_ack_n(slave_ack_n),
      .pend_ack_n(pend_ack_n), .busy_retry_n(busy_retry_n), .lock_split_n(lock_n),
      .type_in(type_in), .ad_in(ad_in));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Waits for one completion signal, chosen by sel, within 200 cycles
   task automatic await(input int sel, output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (n < 200 && !(sel == 0 ? cmd_ready === 1'b1 : sel == 1 ? rsp_valid === 1'b1 :
         sel == 2 ? read_return_strobe_n === 1'b0 : sel == 3 ? dma_ret_ready === 1'b1 :
         guest_grant_n[1] === 1'b0));
      if (n == 200) begin
         mismatches++;
         $display("BAD wait %0d expected 1 seen 0", sel);
      end
   endtask : await
   task automatic take;
      int n;
      await(0, n);
      @(posedge sys_clk) cmd_valid <= 1'b0;
   endtask : take
   task automatic io(input logic w, input logic [31:0] a, input logic [31:0] d, input logic go);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      rdata <= d;
      if (go) take;
   endtask : io
   task automatic pop(input logic [31:0] d, input logic [1:0] st);
      int n;
      await(1, n);
      if (st == `SRH_ST_OK) chk("rsp_data", d, rsp_data);
      chk("rsp_status", {30'h0, st}, {30'h0, rsp_status});
      @(posedge sys_clk) rsp_ready <= 1'b1;
      @(posedge sys_clk) rsp_ready <= 1'b0;
   endtask : pop
   task automatic ret(input logic [31:0] d);
      @(posedge sys_clk) ret_data <= d;
      ret_go <= 1'b1;
      @(posedge sys_clk) ret_go <= 1'b0;
   endtask : ret
   task automatic t_fill;
      int n;
      for (int i = 0; i < 4; i++) begin
         io(1'b0, 32'h100 + i, 32'h0a00 + i, 1'b1);
         chk("pend_line", 32'h0, {31'h0, pc_seen});
      end
      io(1'b0, 32'h104, 32'h0a04, 1'b0);
      n = 0;
      repeat (30) begin
         @(negedge sys_clk);
         n += cmd_ready;
      end
      chk("full_hold", 32'h0, 32'(n));
      pop(32'h0a00, `SRH_ST_OK);
      take;
      for (int i = 1; i < 5; i++) pop(32'h0a00 + i, `SRH_ST_OK);
   endtask : t_fill
   task automatic t_write;
      @(posedge sys_clk) dly <= 2'h3;
      io(1'b1, 32'h200, 32'hbeef_0001, 1'b1);
      chk("wr_type", {28'h0, `SRH_TYPE_WRITE}, {28'h0, ty_seen});
      chk("wr_addr", 32'h200, ad_seen);
      chk("wr_data", 32'hbeef_0001, wd_seen);
      chk("wr_oe", 32'h1, {31'h0, oe_seen});
      dly <= 2'h0;
   endtask : t_write
   task automatic t_pend;
      @(posedge sys_clk) mode <= 2'h1;
      io(1'b0, 32'h300, 32'h0, 1'b1);
      mode <= 2'h0;
      io(1'b0, 32'h304, 32'h0b04, 1'b1);
      chk("pend_line", 32'h1, {31'h0, pc_seen});
      pop(32'h0b04, `SRH_ST_OK);
      ret(32'h0c00);
      pop(32'h0c00, `SRH_ST_OK);
      io(1'b0, 32'h308, 32'h0b08, 1'b1);
      chk("pend_line", 32'h0, {31'h0, pc_seen});
      pop(32'h0b08, `SRH_ST_OK);
   endtask : t_pend
   // Kind 0: wait out the gap, 1: hard error drops it, 2: a memory return ends the wait
   task automatic t_retry(input logic [1:0] kind);
      int n0;
      int n;
      n0 = txn_n;
      @(posedge sys_clk) mode <= 2'h2;
      fork
         io(1'b0, 32'h400, 32'h0d00, 1'b1);
         begin
            do @(negedge sys_clk); while (txn_n == n0);
            repeat (4) @(posedge sys_clk);
            if (kind == 2'h1) hard_err_in <= 1'b1;
            else mode <= 2'h0;
            if (kind == 2'h2) begin
               dma_ret_valid <= 1'b1;
               dma_ret_last <= 1'b1;
               dma_ret_guest <= 4'h4;
               await(3, n);
               @(posedge sys_clk) dma_ret_valid <= 1'b0;
               dma_ret_last <= 1'b0;
            end
         end
      join
      hard_err_in <= 1'b0;
      mode <= 2'h0;
      if (kind == 2'h1) pop(32'h0, `SRH_ST_PATH);
      else begin
         chk("retry_gap", 32'h1, 32'(kind == 2'h2 ? at_r - prev_at >= 3 && at_r - prev_at <= 16 :
            at_r - prev_at >= 17 && at_r - prev_at <= 28));
         chk("retry_addr", 32'h400, ad_seen);
         pop(32'h0d00, `SRH_ST_OK);
      end
   endtask : t_retry
   task automatic t_lock;
      int n0;
      n0 = txn_n;
      @(posedge sys_clk) mode <= 2'h3;
      io(1'b0, 32'h600, 32'h0a60, 1'b1);
      mode <= 2'h0;
      chk("lock_txns", 32'(n0 + 1), 32'(txn_n));
      pop(32'h0a60, `SRH_ST_OK);
   endtask : t_lock
   task automatic t_stray;
      chk("no_err", 32'h0, {30'h0, errs});
      ret(32'h0e0e);
      repeat (30) @(negedge sys_clk);
      chk("stray_err", 32'h3, {30'h0, errs});
      chk("stray_rsp", 32'h0, {31'h0, rsp_valid});
   endtask : t_stray
   task automatic t_tmo;
      int n;
      @(posedge sys_clk) mode <= 2'h1;
      io(1'b0, 32'h500, 32'h0, 1'b1);
      mode <= 2'h0;
      await(1, n);
      chk("tmo_span", 32'h1, 32'(n >= TMO - 4 && n <= TMO + 4));
      pop(32'h0, `SRH_ST_TMO);
   endtask : t_tmo
   task automatic t_dma;
      int n;
      @(posedge sys_clk) dma_ret_valid <= 1'b1;
      dma_ret_guest <= 4'h4;
      dma_ret_data <= 32'h0f00;
      await(2, n);
      chk("ret_grant", 32'hb, {28'h0, guest_grant_n});
      for (int i = 0; i < 2; i++) begin
         await(3, n);
         chk("ret_data", 32'h0f00 + i, ad_out);
         if (i == 1) chk("ret_free", 32'h1f, {27'h0, read_return_strobe_n, guest_grant_n});
         @(posedge sys_clk) dma_ret_data <= 32'h0f01;
         dma_ret_last <= (i == 0);
         if (i == 1) dma_ret_valid <= 1'b0;
      end
   endtask : t_dma
   task automatic t_grant;
      int n;
      for (int p = 0; p < 2; p++) begin
         @(posedge sys_clk) pend_ok <= p[0];
         req_hi <= 3'h6;
         await(4, n);
         chk("mem_pend", {31'h0, !p[0]}, {31'h0, pend_capable_n});
         @(posedge sys_clk) req_hi <= 3'h7;
         repeat (6) @(posedge sys_clk);
      end
   endtask : t_grant
   initial begin
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_fill();
      t_write();
      t_pend();
      t_retry(2'h0);
      t_retry(2'h1);
      t_retry(2'h2);
      t_lock();
      t_stray();
      t_tmo();
      t_dma();
      t_grant();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      give_verdict();
   end
endmodule : tb_srh_host
`default_nettype wire
